// ---- rtl/plsr_pkg.sv ----
// Shared constants for the parallel-load shift register block
package plsr_pkg;
    localparam int          PLSR_STAGES        = 8;
    localparam int          PLSR_ADDR_W        = 4;
    localparam int          PLSR_DATA_W        = 32;
    // Register byte offsets
    localparam logic [3:0]  PLSR_CTRL_OFS      = 4'h0;
    localparam logic [3:0]  PLSR_STATUS_OFS    = 4'h4;
    // Control register fields
    localparam int          PLSR_CTRL_CLK_BIT  = 0;
    localparam int          PLSR_CTRL_INH_BIT  = 1;
    localparam int          PLSR_CTRL_MODE_BIT = 2;
    localparam int          PLSR_CTRL_SER_BIT  = 3;
    localparam int          PLSR_CTRL_PAR_LSB  = 8;
    localparam int          PLSR_CTRL_USED_W   = 16;
    localparam logic [15:0] PLSR_CTRL_RESET    = 16'h0004;
    // Status register fields
    localparam int          PLSR_STAT_LAST_BIT = 0;
    // AXI response codes
    localparam logic [1:0]  PLSR_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  PLSR_RESP_SLVERR   = 2'h2;
endpackage

// ---- rtl/plsr_stage_if.sv ----
// Carrier between the bus front end and the shift stages
interface plsr_stage_if #(parameter int STAGES = 8);
    logic              clock_level;
    logic              clock_inhibit;
    logic              shift_not_load_select;
    logic              serial_data_in;
    logic [STAGES-1:0] parallel_data;
    logic              last_stage_serial_out;
    modport ctrl (output clock_level, clock_inhibit, shift_not_load_select,
                  serial_data_in, parallel_data, input last_stage_serial_out);
    modport core (input clock_level, clock_inhibit, shift_not_load_select,
                  serial_data_in, parallel_data, output last_stage_serial_out);
endinterface

// ---- rtl/plsr_stages.sv ----
// Eight shift stages with gated clock qualification and overriding clear
module plsr_stages
    import plsr_pkg::*;
#(
    parameter int STAGES = PLSR_STAGES
) (
    // Clock and resets
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  async_clear_n_i,
    // Controls and data
    plsr_stage_if.core sr
);
    logic              gated_prev;
    logic              gated_now;
    logic              gated_rise;
    logic              clear_n;
    logic [STAGES-1:0] stages;
    logic [STAGES-1:0] next_stages;

    // Either input held high blocks clocking; either held low lets the other act as clock
    assign gated_now  = sr.clock_level | sr.clock_inhibit; // R4 R5
    // Inhibit rising while clock is low makes an edge here, as in the part
    assign gated_rise = gated_now & ~gated_prev; // R4 R6 R7
    assign clear_n    = rst_n_i & async_clear_n_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gated_prev <= 1'b1;
        end else begin
            gated_prev <= gated_now;
        end
    end

    assign next_stages[0] = sr.shift_not_load_select ? sr.serial_data_in // R1 R3
                                                     : sr.parallel_data[0]; // R2
    genvar g;
    generate
        for (g = 1; g < STAGES; g++) begin : g_stage
            assign next_stages[g] = sr.shift_not_load_select ? stages[g-1] // R1
                                                             : sr.parallel_data[g]; // R2
        end
    endgenerate

    // Clear acts without the clock and beats every other input
    always_ff @(posedge clk_i or negedge clear_n) begin
        if (!clear_n) begin
            stages <= '0; // R8
        end else if (gated_rise) begin
            stages <= next_stages; // R1 R2
        end
    end

    assign sr.last_stage_serial_out = stages[STAGES-1]; // R9
endmodule

// ---- rtl/plsr_top.sv ----
// AXI4-Lite front end driving the parallel-load shift register
// Functional notes
// R1: Shift high: each qualifying edge shifts; first stage takes serial input.
// R2: Shift low: parallel word loads on the next qualifying edge, not at once.
// R3: During parallel load the serial input enters no stage.
// R4: Internal clock is OR of clock and inhibit; acts on its rising edge.
// R5: Either input held high stops clocking; either held low lets other clock.
// R6: Free-running clock may stay while inhibit pauses the register.
// R7: Controller should raise inhibit only while clock is high.
// R8: Low clear zeroes all stages at once, overriding every input.
// R9: Only the last stage leaves the block; others stay internal.
module plsr_top
    import plsr_pkg::*;
(
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RESETN_I,
    // Overriding clear
    input  wire logic                   ASYNC_CLEAR_N_I,
    // Write address channel
    input  wire logic [PLSR_ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic                   S_AXI_AWVALID_I,
    output logic                        S_AXI_AWREADY_O,
    // Write data channel
    input  wire logic [PLSR_DATA_W-1:0] S_AXI_WDATA_I,
    input  wire logic [3:0]             S_AXI_WSTRB_I,
    input  wire logic                   S_AXI_WVALID_I,
    output logic                        S_AXI_WREADY_O,
    // Write response channel
    output logic [1:0]                  S_AXI_BRESP_O,
    output logic                        S_AXI_BVALID_O,
    input  wire logic                   S_AXI_BREADY_I,
    // Read address channel
    input  wire logic [PLSR_ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic                   S_AXI_ARVALID_I,
    output logic                        S_AXI_ARREADY_O,
    // Read data channel
    output logic [PLSR_DATA_W-1:0]      S_AXI_RDATA_O,
    output logic [1:0]                  S_AXI_RRESP_O,
    output logic                        S_AXI_RVALID_O,
    input  wire logic                   S_AXI_RREADY_I,
    // Serial output
    output logic                        LAST_STAGE_SERIAL_OUT_O
);
    logic                        aw_held;
    logic [PLSR_ADDR_W-1:0]      aw_addr;
    logic                        w_held;
    logic [PLSR_DATA_W-1:0]      w_data;
    logic [3:0]                  w_strb;
    logic [PLSR_CTRL_USED_W-1:0] ctrl;
    logic                        do_write;
    logic [PLSR_DATA_W-1:0]      read_word;

    plsr_stage_if #(.STAGES(PLSR_STAGES)) sr_bus ();

    // Each address and data beat is latched on its own; response needs both
    assign S_AXI_AWREADY_O = ~aw_held & ~S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = ~w_held & ~S_AXI_BVALID_O;
    assign do_write        = aw_held & w_held & ~S_AXI_BVALID_O;

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= PLSR_RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (aw_addr == PLSR_CTRL_OFS || aw_addr == PLSR_STATUS_OFS)
                              ? PLSR_RESP_OKAY : PLSR_RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Control word: byte lanes 0 and 1 hold all used fields
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl <= PLSR_CTRL_RESET;
        end else if (do_write && aw_addr == PLSR_CTRL_OFS) begin
            if (w_strb[0]) begin
                ctrl[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                ctrl[15:8] <= w_data[15:8];
            end
        end
    end

    assign sr_bus.clock_level           = ctrl[PLSR_CTRL_CLK_BIT];
    assign sr_bus.clock_inhibit         = ctrl[PLSR_CTRL_INH_BIT];
    assign sr_bus.shift_not_load_select = ctrl[PLSR_CTRL_MODE_BIT];
    assign sr_bus.serial_data_in        = ctrl[PLSR_CTRL_SER_BIT];
    assign sr_bus.parallel_data         = ctrl[PLSR_CTRL_PAR_LSB +: PLSR_STAGES];

    always_comb begin
        read_word = '0;
        if (S_AXI_ARADDR_I == PLSR_CTRL_OFS) begin
            read_word[PLSR_CTRL_USED_W-1:0] = ctrl;
        end else if (S_AXI_ARADDR_I == PLSR_STATUS_OFS) begin
            // Inner stages are deliberately not readable
            read_word[PLSR_STAT_LAST_BIT] = sr_bus.last_stage_serial_out; // R9
        end
    end

    assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= '0;
            S_AXI_RRESP_O  <= PLSR_RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O  <= read_word;
            S_AXI_RRESP_O  <= (S_AXI_ARADDR_I == PLSR_CTRL_OFS ||
                               S_AXI_ARADDR_I == PLSR_STATUS_OFS)
                              ? PLSR_RESP_OKAY : PLSR_RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    plsr_stages #(.STAGES(PLSR_STAGES)) u_stages (
        .clk_i           (CLK_I),
        .rst_n_i         (RESETN_I),
        .async_clear_n_i (ASYNC_CLEAR_N_I),
        .sr              (sr_bus.core)
    );

    assign LAST_STAGE_SERIAL_OUT_O = sr_bus.last_stage_serial_out; // R9
endmodule

// ---- tb/plsr_properties.sv ----
// Port assertions for the shift register block
module plsr_checker
    import plsr_pkg::*;
(
    input wire logic CLK_I, RESETN_I, ASYNC_CLEAR_N_I, LAST_STAGE_SERIAL_OUT_O,
    input wire logic S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O, S_AXI_RREADY_I,
    input wire logic [PLSR_DATA_W-1:0] S_AXI_RDATA_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_clear_zeroes_out: assert property (!ASYNC_CLEAR_N_I |-> !LAST_STAGE_SERIAL_OUT_O)
        else $error("serial out high under clear");
    a_out_needs_write: assert property ($changed(LAST_STAGE_SERIAL_OUT_O)
        && ASYNC_CLEAR_N_I && $past(ASYNC_CLEAR_N_I) |-> $past(S_AXI_BVALID_O))
        else $error("serial out moved without a write");
    a_b_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
        else $error("write response dropped early");
    a_r_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped early");
    a_read_one_cycle: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    a_write_two_cycles: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O) else $error("write answer late");
    a_ar_refused: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read address taken while busy");
    a_aw_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken while busy");
endmodule
bind plsr_top plsr_checker chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .ASYNC_CLEAR_N_I(ASYNC_CLEAR_N_I), .LAST_STAGE_SERIAL_OUT_O(LAST_STAGE_SERIAL_OUT_O),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .S_AXI_RDATA_O(S_AXI_RDATA_O));

// ---- tb/plsr_master.sv ----
// Bus master standing in for the controlling logic
module plsr_master
    import plsr_pkg::*;
(
    input  wire logic clk_i, awready_i, wready_i, bvalid_i, arready_i, rvalid_i,
    input  wire logic [1:0] bresp_i, rresp_i,
    input  wire logic [31:0] rdata_i,
    output logic [3:0] awaddr_o, araddr_o,
    output logic [31:0] wdata_o,
    output logic awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {awaddr_o, araddr_o, wdata_o, awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
    // Response ready rises with the request and stays up until the answer is taken or 50 cycles pass
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit dn = 0;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        {awvalid_o, wvalid_o, bready_o} <= 3'b111;
        for (int n = 0; n < 50 && !dn; n++) begin
            @(posedge clk_i);
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
            dn = bvalid_i && bready_o;
        end
        bready_o <= 1'b0;
        r = dn ? bresp_i : 2'h3;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit dn = 0;
        @(posedge clk_i);
        araddr_o <= a;
        {arvalid_o, rready_o} <= 2'b11;
        for (int n = 0; n < 50 && !dn; n++) begin
            @(posedge clk_i);
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
            dn = rvalid_i && rready_o;
        end
        rready_o <= 1'b0;
        d = rdata_i;
        r = dn ? rresp_i : 2'h3;
    endtask
endmodule

// ---- tb/tb_parallel_load_shift_register.sv ----
// Testbench for the bus-driven parallel-load shift register
module tb_parallel_load_shift_register
    import plsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n = 0, clr_n = 1, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, sout;
    logic [3:0] awa, ara;
    logic [31:0] wd, rdt, d;
    logic [1:0] brs, rrs, r;
    logic [7:0] m = 8'h00;
    int errors = 0, checks_done = 0;
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    plsr_top dut (.CLK_I(clk), .RESETN_I(rst_n), .ASYNC_CLEAR_N_I(clr_n), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdt), .S_AXI_RRESP_O(rrs), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
        .LAST_STAGE_SERIAL_OUT_O(sout));
    plsr_master bm (.clk_i(clk), .awready_i(awr), .wready_i(wrd), .bvalid_i(bv), .arready_i(arr),
        .rvalid_i(rv), .bresp_i(brs), .rresp_i(rrs), .rdata_i(rdt), .awaddr_o(awa), .araddr_o(ara),
        .wdata_o(wd), .awvalid_o(awv), .wvalid_o(wv), .bready_o(br), .arvalid_o(arv), .rready_o(rr));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        bm.wr(a, v, r);
        cmp({30'h0, r}, {30'h0, er});
        if (r === 2'h3) report_and_stop();
    endtask
    task automatic rreg(input logic [3:0] a, input logic [31:0] ev, input logic [1:0] er);
        bm.rd(a, d, r);
        cmp({30'h0, r}, {30'h0, er});
        if (r === 2'h3) report_and_stop();
        cmp(d, ev);
    endtask
    function automatic logic [31:0] cw(logic c, i, md, s, logic [7:0] p);
        return {16'h0000, p, 4'h0, s, md, i, c};
    endfunction
    // Clock low then high; inhibit only ever rises together with a falling clock bit
    task automatic pulse(input logic md, s, i, input logic [7:0] p);
        wreg(PLSR_CTRL_OFS, cw(1'b0, i, md, s, p), PLSR_RESP_OKAY);
        rreg(PLSR_STATUS_OFS, {31'h0, m[7]}, PLSR_RESP_OKAY);
        wreg(PLSR_CTRL_OFS, cw(1'b1, i, md, s, p), PLSR_RESP_OKAY);
        if (!i) m = md ? {m[6:0], s} : p;
        rreg(PLSR_STATUS_OFS, {31'h0, m[7]}, PLSR_RESP_OKAY);
        cmp({31'h0, sout}, {31'h0, m[7]});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rreg(PLSR_CTRL_OFS, 32'h0000_0004, PLSR_RESP_OKAY);
        rreg(PLSR_STATUS_OFS, 32'h0000_0000, PLSR_RESP_OKAY);
        rreg(4'h8, 32'h0000_0000, PLSR_RESP_SLVERR);
        wreg(4'hC, 32'h0000_00FF, PLSR_RESP_SLVERR);
        pulse(1'b0, 1'b1, 1'b0, 8'h82);
        for (int k = 0; k < 9; k++) pulse(1'b1, k[0] ^ k[2], k == 3, 8'h5A);
        rreg(PLSR_CTRL_OFS, cw(1'b1, 1'b0, 1'b1, 1'b0, 8'h5A), PLSR_RESP_OKAY);
        clr_n <= 1'b0;
        wreg(PLSR_CTRL_OFS, cw(1'b0, 1'b0, 1'b0, 1'b0, 8'hFF), PLSR_RESP_OKAY);
        wreg(PLSR_CTRL_OFS, cw(1'b1, 1'b0, 1'b0, 1'b0, 8'hFF), PLSR_RESP_OKAY);
        rreg(PLSR_STATUS_OFS, 32'h0000_0000, PLSR_RESP_OKAY);
        cmp({31'h0, sout}, 32'h0000_0000);
        rreg(PLSR_CTRL_OFS, cw(1'b1, 1'b0, 1'b0, 1'b0, 8'hFF), PLSR_RESP_OKAY);
        clr_n <= 1'b1;
        m = 8'h00;
        pulse(1'b0, 1'b0, 1'b0, 8'h80);
        report_and_stop();
    end
endmodule
